/* File: include/wdt_pkg.sv */
/*
 * Constants, types and helpers for the windowed watchdog timer.
 * Assumes a 40 MHz system clock and an 8-bit register address space.
 */
package wdt_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  REFRESH_OFS       = 8'h00;
    localparam logic [7:0]  STATUS_OFS        = 8'h04;
    localparam logic [7:0]  COUNT_OFS         = 8'h08;
    localparam logic [7:0]  OPTION_OFS        = 8'hc0;
    localparam logic [7:0]  REFRESH_KEY       = 8'hac;
    localparam logic [7:0]  OPTION_RESET      = 8'h00;

    // Status register fields
    localparam int          STAT_WDT_RST_BIT  = 0;
    localparam int          STAT_RUNNING_BIT  = 1;
    localparam int          STAT_WINDOW_BIT   = 2;
    localparam int          STAT_IRQ_SEEN_BIT = 3;
    localparam int          STAT_ERR_WIN_BIT  = 4;

    // Option byte fields
    localparam int          OPT_IRQ_BIT       = 7;
    localparam int          OPT_WIN_LSB       = 5;
    localparam int          OPT_RUN_BIT       = 4;
    localparam int          OPT_OVF_LSB       = 1;
    localparam int          OPT_STBY_BIT      = 0;

    // ****************************************
    // Timing and widths
    // ****************************************
    localparam int          COUNT_W           = 17;
    localparam int          CHIP_RESET_NS     = 100;
    localparam int          CLK_PERIOD_NS     = 25;
    localparam logic [3:0]  CHIP_RESET_CYCLES = 4'((CHIP_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    typedef struct packed {
        logic       interval_irq_enable;
        logic [1:0] window_sel;
        logic       counter_run_enable;
        logic [2:0] overflow_sel;
        logic       standby_count_enable;
    } option_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } reg_wr_t;

    // Overflow length in low-speed clock cycles
    function automatic logic [COUNT_W-1:0] overflow_count(input logic [2:0] sel);
        logic [COUNT_W-1:0] n;
        n = 17'h00040;
        unique case (sel)
            3'h0: n = 17'h00040;
            3'h1: n = 17'h00080;
            3'h2: n = 17'h00100;
            3'h3: n = 17'h00200;
            3'h4: n = 17'h00800;
            3'h5: n = 17'h02000;
            3'h6: n = 17'h04000;
            3'h7: n = 17'h10000;
        endcase
        return n;
    endfunction

    // First count value at which a refresh is accepted
    function automatic logic [COUNT_W-1:0] window_start(input logic [COUNT_W-1:0] n,
                                                        input logic [1:0]         win);
        logic [COUNT_W-1:0] s;
        s = '0;
        unique case (win)
            2'h1:    s = n >> 1;
            2'h2:    s = n >> 2;
            default: s = '0;
        endcase
        return s;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == REFRESH_OFS) || (a == STATUS_OFS) || (a == COUNT_OFS) || (a == OPTION_OFS);
    endfunction

endpackage

/* File: verilog/ls_edge_detect.sv */
/*
 * Edge detector for the low-speed oscillator clock.
 * Assumes the oscillator level is synchronous to the system clock.
 */
`timescale 1ns/1ps
module ls_edge_detect (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic ls_clk_i,
    output logic      rise_o,
    output logic      fall_o
);

    logic ls_q_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ls_q_r <= 1'b0;
        end else begin
            ls_q_r <= ls_clk_i;
        end
    end

    assign rise_o = ls_clk_i & ~ls_q_r;
    assign fall_o = ~ls_clk_i & ls_q_r;

endmodule

/* File: verilog/axil_reg_slave.sv */
/*
 * AXI4-Lite slave front end: one write and one read at a time.
 * Assumes the parent decodes addresses and supplies read data combinationally.
 */
`timescale 1ns/1ps
module axil_reg_slave (
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    input  wire logic [7:0]    awaddr_i,
    input  wire logic          awvalid_i,
    output logic               awready_o,
    input  wire logic [31:0]   wdata_i,
    input  wire logic [3:0]    wstrb_i,
    input  wire logic          wvalid_i,
    output logic               wready_o,
    output logic [1:0]         bresp_o,
    output logic               bvalid_o,
    input  wire logic          bready_i,
    input  wire logic [7:0]    araddr_i,
    input  wire logic          arvalid_i,
    output logic               arready_o,
    output logic [31:0]        rdata_o,
    output logic [1:0]         rresp_o,
    output logic               rvalid_o,
    input  wire logic          rready_i,
    output logic               wr_en_o,
    output wdt_pkg::reg_wr_t   wr_o,
    output logic [7:0]         rd_addr_o,
    input  wire logic [31:0]   rd_data_i
);

    logic             aw_have_r;
    logic             w_have_r;
    wdt_pkg::reg_wr_t wr_r;

    // ****************************************
    // Write channels
    // ****************************************
    assign awready_o = ~aw_have_r & ~bvalid_o;
    assign wready_o  = ~w_have_r & ~bvalid_o;
    assign wr_en_o   = aw_have_r & w_have_r & ~bvalid_o;
    assign wr_o      = wr_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            wr_r      <= '0;
            bvalid_o  <= 1'b0;
            bresp_o   <= wdt_pkg::RESP_OKAY;
        end else begin
            if (awvalid_i && awready_o) begin
                aw_have_r   <= 1'b1;
                wr_r.addr   <= awaddr_i;
            end
            if (wvalid_i && wready_o) begin
                w_have_r    <= 1'b1;
                wr_r.data   <= wdata_i;
                wr_r.strb   <= wstrb_i;
            end
            if (wr_en_o) begin
                aw_have_r <= 1'b0;
                w_have_r  <= 1'b0;
                bvalid_o  <= 1'b1;
                bresp_o   <= wdt_pkg::addr_mapped(wr_r.addr) ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
            end else if (bvalid_o && bready_i) begin
                bvalid_o  <= 1'b0;
            end
        end
    end

    // ****************************************
    // Read channels
    // ****************************************
    assign arready_o = ~rvalid_o;
    assign rd_addr_o = araddr_i;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_o <= 1'b0;
            rdata_o  <= '0;
            rresp_o  <= wdt_pkg::RESP_OKAY;
        end else if (arvalid_i && arready_o) begin
            rvalid_o <= 1'b1;
            rdata_o  <= rd_data_i;
            rresp_o  <= wdt_pkg::addr_mapped(araddr_i) ? wdt_pkg::RESP_OKAY : wdt_pkg::RESP_SLVERR;
        end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
        end
    end

endmodule

/* File: verilog/window_watchdog_timer.sv */
/*
 * Windowed watchdog timer counting low-speed oscillator cycles.
 * Settings come from an option byte sampled after each reset release.
 * Assumes the option byte, oscillator and standby inputs are synchronous
 * to clk_sys_i, and that rst_n_i is a power-on reset not driven by
 * chip_reset_o, so the watchdog reset flag survives the chip reset.
 */
`timescale 1ns/1ps

module window_watchdog_timer (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  option_byte_i,
    input  wire logic        low_speed_osc_clock_i,
    input  wire logic        standby_i,
    output logic             chip_reset_o,
    output logic             interval_irq_o,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ****************************************
    // Declarations
    // ****************************************
    typedef enum logic [3:0] {
        ST_LOAD = 4'b0001,
        ST_STOP = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_TRIP = 4'b1000
    } wdt_state_t;

    wdt_state_t                    state_r;
    wdt_pkg::option_t              opt_r;
    logic [wdt_pkg::COUNT_W-1:0]   cnt_r;
    logic [wdt_pkg::COUNT_W-1:0]   ovf_n;
    logic [wdt_pkg::COUNT_W-1:0]   win_start;
    logic [wdt_pkg::COUNT_W-1:0]   irq_point;
    logic [3:0]                    trip_cnt_r;
    logic                          ls_rise;
    logic                          ls_fall;
    logic                          count_en;
    logic                          win_open;
    logic                          refresh_req;
    logic                          refresh_ok;
    logic                          err_window;
    logic                          err_overflow;
    logic                          wdt_error;
    logic                          irq_pend_r;
    logic                          wdt_rst_flag_r;
    logic                          irq_seen_r;
    logic                          err_win_flag_r;
    logic                          wr_en;
    wdt_pkg::reg_wr_t              wr;
    logic [7:0]                    rd_addr;
    logic [31:0]                   rd_data;
    logic                          status_w1c;

    // ****************************************
    // Sub-blocks
    // ****************************************
    ls_edge_detect u_ls_edge (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .ls_clk_i  (low_speed_osc_clock_i),
        .rise_o    (ls_rise),
        .fall_o    (ls_fall)
    );

    axil_reg_slave u_axil (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .awaddr_i  (s_axi_awaddr),
        .awvalid_i (s_axi_awvalid),
        .awready_o (s_axi_awready),
        .wdata_i   (s_axi_wdata),
        .wstrb_i   (s_axi_wstrb),
        .wvalid_i  (s_axi_wvalid),
        .wready_o  (s_axi_wready),
        .bresp_o   (s_axi_bresp),
        .bvalid_o  (s_axi_bvalid),
        .bready_i  (s_axi_bready),
        .araddr_i  (s_axi_araddr),
        .arvalid_i (s_axi_arvalid),
        .arready_o (s_axi_arready),
        .rdata_o   (s_axi_rdata),
        .rresp_o   (s_axi_rresp),
        .rvalid_o  (s_axi_rvalid),
        .rready_i  (s_axi_rready),
        .wr_en_o   (wr_en),
        .wr_o      (wr),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data)
    );

    // ****************************************
    // Decoded settings
    // ****************************************
    assign ovf_n     = wdt_pkg::overflow_count(opt_r.overflow_sel);
    assign win_start = wdt_pkg::window_start(ovf_n, opt_r.window_sel);
    assign irq_point = ovf_n - (ovf_n >> 2);
    assign win_open  = (state_r == ST_RUN) && (cnt_r >= win_start);

    // Pause in halt/stop unless standby counting is on
    assign count_en  = (state_r == ST_RUN) && ls_rise &&
                       (!standby_i || opt_r.standby_count_enable);

    // ****************************************
    // Refresh and error detection
    // ****************************************
    assign refresh_req  = wr_en && (wr.addr == wdt_pkg::REFRESH_OFS) && wr.strb[0] &&
                          (wr.data[7:0] == wdt_pkg::REFRESH_KEY) && (state_r == ST_RUN);
    assign refresh_ok   = refresh_req && win_open;
    assign err_window   = refresh_req && !win_open;
    assign err_overflow = count_en && (cnt_r == ovf_n - 17'h00001);
    assign wdt_error    = err_window || err_overflow;

    assign status_w1c   = wr_en && (wr.addr == wdt_pkg::STATUS_OFS) && wr.strb[0];

    // ****************************************
    // Control state machine
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_LOAD;
        end else begin
            unique case (state_r)
                ST_LOAD: begin
                    // Decide from the pin, the latched copy is not loaded yet
                    state_r <= option_byte_i[wdt_pkg::OPT_RUN_BIT] ? ST_RUN : ST_STOP;
                end
                ST_STOP: begin
                    state_r <= ST_STOP;
                end
                ST_RUN: begin
                    if (wdt_error) begin
                        state_r <= ST_TRIP;
                    end
                end
                ST_TRIP: begin
                    if (trip_cnt_r == wdt_pkg::CHIP_RESET_CYCLES - 4'h1) begin
                        state_r <= ST_LOAD;
                    end
                end
                default: begin
                    state_r <= ST_LOAD;
                end
            endcase
        end
    end

    // Option byte sampled at each reset release
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opt_r <= wdt_pkg::OPTION_RESET;
        end else if (state_r == ST_TRIP || state_r == ST_LOAD) begin
            opt_r <= option_byte_i;
        end
    end

    // ****************************************
    // Chip reset pulse
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trip_cnt_r <= 4'h0;
        end else if (state_r == ST_TRIP) begin
            trip_cnt_r <= trip_cnt_r + 4'h1;
        end else begin
            trip_cnt_r <= 4'h0;
        end
    end

    assign chip_reset_o = (state_r == ST_TRIP);

    // ****************************************
    // Counter
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= '0;
        end else if (state_r != ST_RUN || refresh_ok) begin
            cnt_r <= '0;
        end else if (count_en) begin
            cnt_r <= cnt_r + 17'h00001;
        end
    end

    // ****************************************
    // Interval interrupt
    // ****************************************
    // Armed when the count reaches 75%, fires on the next oscillator fall
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_pend_r <= 1'b0;
        end else if (state_r != ST_RUN || refresh_ok) begin
            irq_pend_r <= 1'b0;
        end else if (count_en && opt_r.interval_irq_enable &&
                     (cnt_r + 17'h00001 == irq_point)) begin
            irq_pend_r <= 1'b1;
        end else if (ls_fall) begin
            irq_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interval_irq_o <= 1'b0;
        end else begin
            interval_irq_o <= irq_pend_r && ls_fall && (state_r == ST_RUN) && !refresh_ok;
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdt_rst_flag_r <= 1'b0;
        end else if (wdt_error && state_r == ST_RUN) begin
            wdt_rst_flag_r <= 1'b1;
        end else if (status_w1c && wr.data[wdt_pkg::STAT_WDT_RST_BIT]) begin
            wdt_rst_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_win_flag_r <= 1'b0;
        end else if (err_window) begin
            err_win_flag_r <= 1'b1;
        end else if (err_overflow && state_r == ST_RUN) begin
            err_win_flag_r <= 1'b0;
        end else if (status_w1c && wr.data[wdt_pkg::STAT_ERR_WIN_BIT]) begin
            err_win_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_seen_r <= 1'b0;
        end else if (interval_irq_o) begin
            irq_seen_r <= 1'b1;
        end else if (status_w1c && wr.data[wdt_pkg::STAT_IRQ_SEEN_BIT]) begin
            irq_seen_r <= 1'b0;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (rd_addr)
            wdt_pkg::STATUS_OFS: begin
                rd_data[wdt_pkg::STAT_WDT_RST_BIT]  = wdt_rst_flag_r;
                rd_data[wdt_pkg::STAT_RUNNING_BIT]  = (state_r == ST_RUN);
                rd_data[wdt_pkg::STAT_WINDOW_BIT]   = win_open;
                rd_data[wdt_pkg::STAT_IRQ_SEEN_BIT] = irq_seen_r;
                rd_data[wdt_pkg::STAT_ERR_WIN_BIT]  = err_win_flag_r;
            end
            wdt_pkg::COUNT_OFS: begin
                rd_data[wdt_pkg::COUNT_W-1:0] = cnt_r;
            end
            wdt_pkg::OPTION_OFS: begin
                rd_data[7:0] = opt_r;
            end
            default: begin
                rd_data = 32'h0000_0000;
            end
        endcase
    end

endmodule

/* File: testbench/window_watchdog_timer_chk.sv */
/*
 * Assertion checker for the windowed watchdog timer top-level ports.
 * Assumes it is bound to the design from the testbench top file.
 */
`timescale 1ns/1ps
module window_watchdog_timer_chk (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  option_byte_i,
    input wire logic        chip_reset_o,
    input wire logic        interval_irq_o,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ****************************************
    // Properties
    // ****************************************
    chk_reset_pulse_len:
        assert property ($rose(chip_reset_o) |-> chip_reset_o [*4] ##1 !chip_reset_o) else $error("reset pulse length");
    chk_irq_single_pulse:
        assert property (interval_irq_o |=> !interval_irq_o) else $error("irq longer than one cycle");
    chk_irq_enable_gate:
        assert property (interval_irq_o |-> option_byte_i[wdt_pkg::OPT_IRQ_BIT]) else $error("irq while disabled");
    chk_stopped_quiet:
        assert property (!option_byte_i[wdt_pkg::OPT_RUN_BIT] |-> !chip_reset_o && !interval_irq_o)
        else $error("activity while stopped");
    chk_write_resp_delay:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_write_resp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_read_resp_delay:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
    chk_read_data_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_read_addr_block:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read address taken while busy");
    cover property ($rose(chip_reset_o));
    cover property (interval_irq_o);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: testbench/tb_window_watchdog_timer.sv */
/*
 * Self-checking testbench for the windowed watchdog timer over AXI4-Lite.
 * Assumes a fast oscillator of four system clocks and overflow codes 000 and 001.
 */
`timescale 1ns/1ps
module tb_window_watchdog_timer;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [7:0]  opt = 8'hb0, awaddr = 8'h00, araddr = 8'h00;
    logic        osc = 1'b0, stby = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0]  osc_div = 2'h0, bresp, rresp;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, chip_rst, irq;
    int          bad_count = 0, num_checks = 0;

    window_watchdog_timer window_watchdog_timer_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .option_byte_i(opt), .low_speed_osc_clock_i(osc), .standby_i(stby), .chip_reset_o(chip_rst),
        .interval_irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(araddr), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_rdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v), .s_axi_rready(r_r));

    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        osc_div <= osc_div + 2'h1;
        if (osc_div[0]) osc <= ~osc;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timed_out;
        bad_count++;
        $display("BAD %0t wait ran out", $time);
        print_verdict;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb, tr;
        @(posedge clk_sys_i);
        awaddr <= a; wdata <= d; aw_v <= 1'b1; w_v <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk_sys_i);
            ta = aw_v && aw_rdy; tw = w_v && w_rdy; tb = b_v; tr = b_r;
            if (tb) check({30'h0, bresp}, {30'h0, er});
            @(posedge clk_sys_i);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
            if (tb && tr) begin
                b_r <= 1'b0;
                return;
            end
            if (tb) b_r <= 1'b1;
        end
        timed_out;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [1:0] er);
        logic ta, tv, tr;
        @(posedge clk_sys_i);
        araddr <= a; ar_v <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk_sys_i);
            ta = ar_v && ar_rdy; tv = r_v; tr = r_r; rd = rdata;
            if (tv && tr) check({30'h0, rresp}, {30'h0, er});
            @(posedge clk_sys_i);
            if (ta) ar_v <= 1'b0;
            if (tv && tr) begin
                r_r <= 1'b0;
                return;
            end
            if (tv) r_r <= 1'b1;
        end
        timed_out;
    endtask
    task automatic wait_high(input logic sel, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(negedge clk_sys_i);
            if ((sel ? irq : chip_rst) === 1'b1) return;
        end
        timed_out;
    endtask
    task automatic restart(input logic [7:0] o);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        opt <= o;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask
    task automatic poll_count(input logic [31:0] lo);
        for (int n = 0; n < 200; n++) begin
            rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY);
            if (rd >= lo) return;
        end
        timed_out;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        restart(8'hb0);
        rd_reg(wdt_pkg::OPTION_OFS, wdt_pkg::RESP_OKAY); check(rd, 32'hb0);
        rd_reg(wdt_pkg::STATUS_OFS, wdt_pkg::RESP_OKAY); check(rd & 32'h2, 32'h2);
        rd_reg(8'h10, wdt_pkg::RESP_SLVERR);
        wr(8'h10, 32'h0, wdt_pkg::RESP_SLVERR);
        wr(wdt_pkg::REFRESH_OFS, 32'hac, wdt_pkg::RESP_OKAY);
        wait_high(1'b0, 20);
        repeat (10) @(posedge clk_sys_i);
        rd_reg(wdt_pkg::STATUS_OFS, wdt_pkg::RESP_OKAY); check(rd & 32'h11, 32'h11);
        wr(wdt_pkg::STATUS_OFS, 32'h19, wdt_pkg::RESP_OKAY);
        rd_reg(wdt_pkg::STATUS_OFS, wdt_pkg::RESP_OKAY); check(rd & 32'h11, 32'h0);
        poll_count(32'd40);
        wr(wdt_pkg::REFRESH_OFS, 32'hac, wdt_pkg::RESP_OKAY);
        rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY); check(rd < 32'd4, 32'h1);
        wait_high(1'b1, 400);
        rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY); check(rd >= 32'd48 && rd <= 32'd50, 32'h1);
        wait_high(1'b0, 200);
        repeat (10) @(posedge clk_sys_i);
        rd_reg(wdt_pkg::STATUS_OFS, wdt_pkg::RESP_OKAY); check(rd & 32'h11, 32'h1);
        stby <= 1'b1;
        rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY); wdata <= rd;
        repeat (40) @(posedge clk_sys_i);
        rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY); check(rd, wdata);
        stby <= 1'b0;
        restart(8'h62);
        rd_reg(wdt_pkg::STATUS_OFS, wdt_pkg::RESP_OKAY); check(rd & 32'h2, 32'h0);
        repeat (300) @(posedge clk_sys_i);
        rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY); check(rd, 32'h0);
        restart(8'h70);
        wr(wdt_pkg::REFRESH_OFS, 32'hac, wdt_pkg::RESP_OKAY);
        repeat (220) @(posedge clk_sys_i);
        rd_reg(wdt_pkg::STATUS_OFS, wdt_pkg::RESP_OKAY); check(rd & 32'h9, 32'h0);
        restart(8'h50);
        poll_count(32'd20);
        wr(wdt_pkg::REFRESH_OFS, 32'hac, wdt_pkg::RESP_OKAY);
        repeat (10) @(posedge clk_sys_i);
        rd_reg(wdt_pkg::STATUS_OFS, wdt_pkg::RESP_OKAY); check(rd & 32'h1, 32'h0);
        restart(8'h73);
        stby <= 1'b1;
        rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY); wdata <= rd;
        repeat (40) @(posedge clk_sys_i);
        rd_reg(wdt_pkg::COUNT_OFS, wdt_pkg::RESP_OKAY); check(rd > wdata, 32'h1);
        poll_count(32'd100);
        wait_high(1'b0, 200);
        print_verdict;
    end
endmodule

bind window_watchdog_timer window_watchdog_timer_chk window_watchdog_timer_chk_inst (.clk_sys_i, .rst_n_i,
    .option_byte_i, .chip_reset_o, .interval_irq_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);
